// ---- hdl/bufmem_pkg.sv ----
package bufmem_pkg;
   // Organisation
   localparam int NUM_BLOCKS = 32;
   localparam int BLOCK_BITS = 4096;
   localparam int NUM_BANKS = 4;
   localparam int BLOCKS_PER_BANK = 8;
   localparam int WAYS = 4;
   localparam int BLK_W = 5;
   localparam int BIT_W = 12;
   localparam int LOC_W = 8;
   localparam logic [BIT_W-1:0] LAST_BIT = 12'hfff;
   localparam logic [1:0] ACCESS_PHASE = 2'h3;
   localparam logic [3:0] IDLE_PHASE = 4'hf;

   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int REFRESH_MAX_HZ = 20_000;
   localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_MAX_HZ + 1;

   // Register map, byte addresses
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] REG_SELECT = 5'h04;
   localparam logic [ADDR_W-1:0] REG_CMD = 5'h08;
   localparam logic [ADDR_W-1:0] REG_FLAGS = 5'h0c;
   localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;

   // Field positions
   localparam int CTRL_MANUAL = 0;
   localparam int CTRL_DESTRUCTIVE = 1;
   localparam int CMD_READ = 0;
   localparam int CMD_CLEAR = 1;
   localparam int ST_BUSY = 0;
   localparam int ST_OVERFLOW = 1;
   localparam int ST_READ_PEND = 2;
   localparam int ST_CUR_LSB = 8;
   localparam int ST_NEXT_LSB = 16;
   localparam int ST_LOC_LSB = 24;

   // Reset values
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [31:0] SELECT_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_READ = 2'b11
   } state_type;

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [31:0] writedata;
   } avl_req_type;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } avl_rsp_type;
endpackage

// ---- hdl/block_store.sv ----
`timescale 1ns/100ps
module block_store #(
   parameter int BLOCKS = 32,
   parameter int BITS = 4096
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [$clog2(BLOCKS*BITS)-1:0] addr,
   input wire logic wr_bit,
   output logic rd_bit
);
   // Recirculating storage, kept until overwritten
   logic mem [0:BLOCKS*BITS-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wr_bit;
      end
      rd_bit <= mem[addr];
   end
endmodule

// ---- hdl/block_buffer_memory_control.sv ----
`timescale 1ns/100ps
// Contract
// RULE1 - 32 blocks of 4096 bits each
// RULE2 - Source gives NRZ bits with low valid
// RULE3 - Output NRZ bits, low valid, FIFO order
// RULE4 - Transfers run at input clock rate
// RULE5 - Idle storage clocked below 20 kHz
// RULE6 - Four banks of four, eight blocks each
// RULE7 - Access bank quarter rate, others sixteenth
// RULE8 - Any block or ordered set accessible
// RULE9 - Reset applied once clock runs
// RULE10 - Per-block select and in-use flag
// RULE11 - Manual mode uses selected blocks only
// RULE12 - Auto mode: free write, used read
// RULE13 - Always ready to write; read on request
// RULE14 - Nondestructive read keeps flag and data
// RULE15 - Destructive read clears block flag
// RULE16 - Clear command clears selected flags
// RULE17 - Busy throughout every transfer
// RULE18 - Overflow when no eligible block, off reading
// RULE19 - Clock source runs continuously
// RULE20 - Output current and next block addresses
// RULE21 - Data kept unless overwritten
// RULE22 - Each burst starts at block start
// RULE23 - Short burst padded to block end
// RULE24 - Input during read is lost
// RULE25 - 8-bit location counter, zero marks start
// RULE26 - Next block searched ascending from current
module block_buffer_memory_control #(
   parameter int REFRESH_DIV = bufmem_pkg::REFRESH_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire bufmem_pkg::avl_req_type avl_req,
   output bufmem_pkg::avl_rsp_type avl_rsp,
   input wire logic din,
   input wire logic din_avail_n,
   output logic dout,
   output logic dout_avail_n,
   output logic busy,
   output logic overflow,
   output logic [bufmem_pkg::NUM_BLOCKS-1:0] in_use,
   output logic [bufmem_pkg::BLK_W-1:0] cur_block,
   output logic [bufmem_pkg::BLK_W-1:0] next_block,
   output logic [bufmem_pkg::LOC_W-1:0] location_counter,
   output logic access_bank_clk,
   output logic other_bank_clk
);
   import bufmem_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   state_type state_r, state_nxt;
   logic [1:0] ctrl_r;
   logic [NUM_BLOCKS-1:0] select_r, flags_r, flags_nxt, done_r, done_nxt;
   logic [BLK_W-1:0] cur_r, cur_nxt, next_r;
   logic [BIT_W-1:0] bit_r, bit_nxt;
   logic [LOC_W-1:0] loc_r;
   logic [$clog2(REFRESH_DIV)-1:0] refresh_r;
   logic read_pend_r, burst_r, burst_nxt, rd_valid_r;
   logic busy_r, overflow_r, dout_r, dout_avail_n_r, acc_clk_r, oth_clk_r;
   avl_rsp_type rsp_r;
   logic rd_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Search helper
   function automatic logic [BLK_W:0] find_after(input logic [NUM_BLOCKS-1:0] set,
                                                 input logic [BLK_W-1:0] from);
      logic [BLK_W:0] res;
      logic [BLK_W-1:0] idx;
      res = '0;
      idx = '0;
      for (int i = NUM_BLOCKS; i >= 1; i--) begin
         idx = from + BLK_W'(i);
         if (set[idx]) begin
            res = {1'b1, idx};
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire req_w = avl_req.read | avl_req.write;
   wire acc_w = req_w & ~rsp_r.waitrequest;
   wire wr_acc_w = acc_w & avl_req.write;
   wire wr_ctrl_w = wr_acc_w & (avl_req.address == REG_CTRL);
   wire wr_sel_w = wr_acc_w & (avl_req.address == REG_SELECT);
   wire wr_cmd_w = wr_acc_w & (avl_req.address == REG_CMD);
   wire read_cmd_w = wr_cmd_w & avl_req.writedata[CMD_READ];
   wire clear_cmd_w = wr_cmd_w & avl_req.writedata[CMD_CLEAR];
   wire manual_w = ctrl_r[CTRL_MANUAL];
   wire destructive_w = ctrl_r[CTRL_DESTRUCTIVE];
   wire [31:0] status_w = {loc_r, 3'h0, next_r, 3'h0, cur_r, 5'h00,
                           read_pend_r, overflow_r, busy_r};
   wire [31:0] rdata_w = (avl_req.address == REG_CTRL) ? {30'h0, ctrl_r} :
                         (avl_req.address == REG_SELECT) ? select_r :
                         (avl_req.address == REG_FLAGS) ? flags_r :
                         (avl_req.address == REG_STATUS) ? status_w : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Block eligibility
   wire [NUM_BLOCKS-1:0] mask_w = manual_w ? select_r : '1; // RULE11 RULE12
   wire [NUM_BLOCKS-1:0] cur_onehot_w = NUM_BLOCKS'(1) << cur_r;
   wire [NUM_BLOCKS-1:0] wr_set_w = ~flags_r & mask_w & ~cur_onehot_w; // RULE12
   wire [NUM_BLOCKS-1:0] rd_set_w = flags_r & mask_w & ~done_r & ~cur_onehot_w; // RULE12
   wire [NUM_BLOCKS-1:0] wr_any_w = ~flags_r & mask_w;
   wire [NUM_BLOCKS-1:0] rd_any_w = flags_r & mask_w & ~done_r;
   wire [BLK_W:0] wr_first_w = find_after(wr_any_w, cur_r); // RULE26
   wire [BLK_W:0] rd_first_w = find_after(rd_any_w, cur_r); // RULE26
   wire [BLK_W:0] wr_next_w = find_after(wr_set_w, cur_r); // RULE26
   wire [BLK_W:0] rd_next_w = find_after(rd_set_w, cur_r); // RULE8
   wire [BLK_W:0] next_sel_w = (state_r == ST_READ) ? rd_next_w : wr_next_w;
   wire in_valid_w = ~din_avail_n; // RULE2
   wire block_end_w = (state_r != ST_IDLE) && (bit_r == LAST_BIT);
   wire start_wr_w = (state_r == ST_IDLE) && in_valid_w && wr_first_w[BLK_W]; // RULE13 RULE24
   wire start_rd_w = (state_r == ST_IDLE) && !in_valid_w && read_pend_r
                     && rd_first_w[BLK_W];
   wire start_w = start_wr_w | start_rd_w;
   wire we_w = (state_r == ST_WRITE) | start_wr_w; // RULE22
   wire wr_bit_w = (burst_r | start_wr_w) & in_valid_w & din; // RULE23
   wire [BLK_W+BIT_W-1:0] mem_addr_w = {start_wr_w ? wr_first_w[BLK_W-1:0] : cur_r, bit_r};
   wire refresh_tick_w = (refresh_r == ($clog2(REFRESH_DIV))'(REFRESH_DIV - 1));
   wire loc_step_w = (state_r == ST_IDLE) ? refresh_tick_w
                     : (bit_r[3:0] == IDLE_PHASE); // RULE5 RULE7
   wire overflow_nxt_w = (state_r != ST_READ) && (wr_any_w == '0); // RULE18

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_nxt = state_r;
      cur_nxt = cur_r;
      bit_nxt = bit_r;
      burst_nxt = burst_r;
      done_nxt = done_r;
      flags_nxt = flags_r;
      if (clear_cmd_w) begin
         flags_nxt = flags_nxt & ~select_r; // RULE16
      end
      case (state_r)
         ST_IDLE: begin
            bit_nxt = {{(BIT_W-1){1'b0}}, start_wr_w}; // RULE22
            if (start_wr_w) begin
               state_nxt = ST_WRITE; // RULE22
               cur_nxt = wr_first_w[BLK_W-1:0];
               burst_nxt = 1'b1;
            end else if (start_rd_w) begin
               state_nxt = ST_READ;
               cur_nxt = rd_first_w[BLK_W-1:0];
            end else begin
               done_nxt = '0;
            end
         end
         ST_WRITE: begin
            bit_nxt = bit_r + 1'b1; // RULE4
            if (!in_valid_w) begin
               burst_nxt = 1'b0;
            end
            if (block_end_w) begin
               flags_nxt[cur_r] = 1'b1; // RULE10
               if (burst_nxt && wr_next_w[BLK_W]) begin
                  cur_nxt = wr_next_w[BLK_W-1:0];
               end else begin
                  state_nxt = ST_IDLE; // RULE23
                  burst_nxt = 1'b0;
               end
            end
         end
         ST_READ: begin
            bit_nxt = bit_r + 1'b1;
            if (block_end_w) begin
               done_nxt[cur_r] = 1'b1;
               if (destructive_w) begin
                  flags_nxt[cur_r] = 1'b0; // RULE15 RULE14
               end
               if (rd_next_w[BLK_W]) begin
                  cur_nxt = rd_next_w[BLK_W-1:0];
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin // RULE9
         state_r <= ST_IDLE;
         cur_r <= '0;
         bit_r <= '0;
         burst_r <= 1'b0;
         done_r <= '0;
         flags_r <= '0;
      end else begin
         state_r <= state_nxt;
         cur_r <= cur_nxt;
         bit_r <= bit_nxt;
         burst_r <= burst_nxt;
         done_r <= done_nxt;
         flags_r <= flags_nxt;
      end
   end

   // Read request, held until the read sequence drains or no block is eligible to read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         read_pend_r <= 1'b0;
      end else if (read_cmd_w) begin
         read_pend_r <= 1'b1; // RULE13
      end else if (state_r == ST_READ && state_nxt == ST_IDLE) begin
         read_pend_r <= 1'b0;
      end else if (start_w == 1'b0 && state_r == ST_IDLE && read_pend_r
                   && !rd_first_w[BLK_W]) begin
         read_pend_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage timing and location counter
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         refresh_r <= '0;
         loc_r <= '0;
         acc_clk_r <= 1'b0;
         oth_clk_r <= 1'b0;
      end else begin
         refresh_r <= refresh_tick_w ? '0 : refresh_r + 1'b1;
         acc_clk_r <= (state_r != ST_IDLE) && (bit_r[1:0] == ACCESS_PHASE); // RULE7
         oth_clk_r <= loc_step_w; // RULE5 RULE21
         if (start_w) begin
            loc_r <= '0; // RULE25
         end else if (loc_step_w) begin
            loc_r <= loc_r + 1'b1; // RULE25
         end
      end
   end

   block_store #(
      .BLOCKS(NUM_BLOCKS),
      .BITS(BLOCK_BITS)
   ) u_store (
      .clk(clk),
      .wr_en(we_w),
      .addr(mem_addr_w),
      .wr_bit(wr_bit_w),
      .rd_bit(rd_bit)
   ); // RULE1 RULE6

   ////////////////////////////////////////////////////////////////////////////
   // Output stream and status
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_valid_r <= 1'b0;
         dout_r <= 1'b0;
         dout_avail_n_r <= 1'b1;
         busy_r <= 1'b0;
         overflow_r <= 1'b0;
         next_r <= '0;
      end else begin
         rd_valid_r <= (state_r == ST_READ);
         dout_r <= rd_valid_r & rd_bit; // RULE3
         dout_avail_n_r <= ~rd_valid_r; // RULE3
         busy_r <= (state_nxt != ST_IDLE); // RULE17
         overflow_r <= overflow_nxt_w; // RULE18
         next_r <= next_sel_w[BLK_W-1:0]; // RULE20
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register bus slave
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r <= CTRL_RESET;
         select_r <= SELECT_RESET;
         rsp_r <= '{waitrequest: 1'b1, readdata: 32'h0000_0000};
      end else begin
         rsp_r.waitrequest <= ~(req_w & rsp_r.waitrequest);
         if (req_w & rsp_r.waitrequest) begin
            rsp_r.readdata <= avl_req.read ? rdata_w : 32'h0000_0000;
         end
         if (wr_ctrl_w) begin
            ctrl_r <= avl_req.writedata[1:0];
         end
         if (wr_sel_w) begin
            select_r <= avl_req.writedata; // RULE10
         end
      end
   end

   assign avl_rsp = rsp_r;
   assign dout = dout_r;
   assign dout_avail_n = dout_avail_n_r;
   assign busy = busy_r;
   assign overflow = overflow_r;
   assign in_use = flags_r;
   assign cur_block = cur_r;
   assign next_block = next_r;
   assign location_counter = loc_r;
   assign access_bank_clk = acc_clk_r;
   assign other_bank_clk = oth_clk_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_overflow_read;
      state_r == ST_READ |=> !overflow_r;
   endproperty
   a_overflow_read: assert property (p_overflow_read) else $error("overflow during read"); // RULE18

   property p_loc_start;
      start_w |=> loc_r == 8'h00;
   endproperty
   a_loc_start: assert property (p_loc_start) else $error("block not started at zero"); // RULE25

   property p_write_flag;
      (state_r == ST_WRITE && bit_r == LAST_BIT) |=> flags_r[$past(cur_r)];
   endproperty
   a_write_flag: assert property (p_write_flag) else $error("written block not flagged"); // RULE10

   property p_read_no_write;
      state_r == ST_READ |-> !we_w;
   endproperty
   a_read_no_write: assert property (p_read_no_write) else $error("write during read"); // RULE24

   property p_dout_timing;
      state_r == ST_READ |-> ##2 !dout_avail_n_r;
   endproperty
   a_dout_timing: assert property (p_dout_timing) else $error("output valid late"); // RULE3

   property p_nondestructive_read_keeps;
      (state_r == ST_READ && !destructive_w && !clear_cmd_w) |=> flags_r == $past(flags_r);
   endproperty
   a_nondestructive_read_keeps: assert property (p_nondestructive_read_keeps) else $error("flags changed in nondestructive read"); // RULE14

   property p_dro_clears;
      (state_r == ST_READ && bit_r == LAST_BIT && destructive_w)
         |=> !flags_r[$past(cur_r)];
   endproperty
   a_dro_clears: assert property (p_dro_clears) else $error("destructive read left flag"); // RULE15

   property p_access_quarter;
      acc_clk_r |=> !acc_clk_r ##1 !acc_clk_r ##1 !acc_clk_r;
   endproperty
   a_access_quarter: assert property (p_access_quarter) else $error("access clock too fast"); // RULE7

   property p_busy;
      busy_r == (state_r != ST_IDLE);
   endproperty
   a_busy: assert property (p_busy) else $error("busy mismatch"); // RULE17

   property p_clear_sel;
      (clear_cmd_w && state_r == ST_IDLE) |=> (flags_r & $past(select_r)) == '0;
   endproperty
   a_clear_sel: assert property (p_clear_sel) else $error("clear left selected flags"); // RULE16

   property p_bus_answer;
      (req_w && rsp_r.waitrequest) |=> !rsp_r.waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

   c_write: cover property (start_wr_w ##1 state_r == ST_WRITE);
   c_read: cover property (start_rd_w ##1 state_r == ST_READ);
   c_chain: cover property (state_r == ST_WRITE && block_end_w && state_nxt == ST_WRITE);
   c_overflow: cover property (overflow_r);
endmodule

// ---- verification/serial_far_side.sv ----
`timescale 1ns/100ps
module serial_far_side (
   input wire logic clk,
   output logic din,
   output logic din_avail_n,
   input wire logic dout,
   input wire logic dout_avail_n
);
   logic got[$];

   initial begin
      din = 1'b0;
      din_avail_n = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source: one bit per rising edge, bit 0 first
   task automatic send(input logic [31:0] bits, input int len);
      for (int i = 0; i < len; i++) begin
         @(posedge clk);
         din <= bits[i];
         din_avail_n <= 1'b0;
      end
      @(posedge clk);
      din_avail_n <= 1'b1;
      // Line not held after the burst
      din <= ~bits[len-1];
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Sink: collect bits qualified by the low valid
   always @(posedge clk) begin
      if (dout_avail_n === 1'b0) begin
         got.push_back(dout);
      end
   end
endmodule

// ---- verification/block_buffer_memory_control_tb.sv ----
`timescale 1ns/100ps
module block_buffer_memory_control_tb;
   import bufmem_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   avl_req_type avl_req = '0;
   avl_rsp_type avl_rsp;
   logic din, din_avail_n, dout, dout_avail_n, busy, overflow, acc_clk, oth_clk;
   logic [NUM_BLOCKS-1:0] in_use;
   logic [BLK_W-1:0] cur_block, next_block;
   logic [LOC_W-1:0] location_counter;
   logic [31:0] rd;
   int failures = 0;
   int n_compared = 0;
   int n_acc = 0;
   int n_oth = 0;

   always #5 clk = ~clk;

   block_buffer_memory_control #(.REFRESH_DIV(16)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .avl_req(avl_req), .avl_rsp(avl_rsp),
      .din(din), .din_avail_n(din_avail_n), .dout(dout), .dout_avail_n(dout_avail_n),
      .busy(busy), .overflow(overflow), .in_use(in_use), .cur_block(cur_block),
      .next_block(next_block), .location_counter(location_counter),
      .access_bank_clk(acc_clk), .other_bank_clk(oth_clk)
   );

   serial_far_side i_far (
      .clk(clk), .din(din), .din_avail_n(din_avail_n),
      .dout(dout), .dout_avail_n(dout_avail_n)
   );

   // Bank clock pulses seen during transfers
   always @(posedge clk) begin
      if (busy === 1'b1) begin
         n_acc <= n_acc + int'(acc_clk);
         n_oth <= n_oth + int'(oth_clk);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avl_req.read <= ~wr;
      avl_req.write <= wr;
      avl_req.address <= a;
      avl_req.writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avl_rsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         failures++;
         $display("unexpected at %0t: bus stalled %h %h", $time, a, d);
      end
      rd = avl_rsp.readdata;
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
   endtask

   task automatic rreg(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask

   task automatic wait_busy(input logic lvl, input int lim);
      int n;
      n = 0;
      while (busy !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) begin
         failures++;
         $display("unexpected at %0t: busy %h expected %h", $time, busy, lvl);
      end
   endtask

   task automatic write_blk(input logic [31:0] pat, input int len, input logic [31:0] flg,
                            input logic [4:0] blk);
      int a0;
      int o0;
      a0 = n_acc;
      o0 = n_oth;
      i_far.send(pat, len);
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 5000);
      repeat (2) @(posedge clk);
      check({27'h0, cur_block}, {27'h0, blk});
      check(32'(n_acc - a0 >= 1023 && n_acc - a0 <= 1024), 32'h1);
      check(32'((n_acc - a0) / 4 - (n_oth - o0) <= 1), 32'h1);
      rreg(REG_FLAGS, flg);
      check(in_use, flg);
   endtask

   task automatic chk_blk(input int base, input logic [31:0] pat, input int len);
      int bad;
      bad = 0;
      for (int k = 0; k < BLOCK_BITS; k++) begin
         if (i_far.got[base+k] !== ((k < len) ? pat[k] : 1'b0)) begin
            bad++;
         end
      end
      check(32'(bad), 32'h0);
   endtask

   task automatic read_all(input logic [31:0] ctrl, input logic disturb);
      bus(1'b1, REG_CTRL, ctrl);
      i_far.got.delete();
      bus(1'b1, REG_CMD, 32'h0000_0001);
      wait_busy(1'b1, 100);
      if (disturb) begin
         i_far.send(32'h0000_001f, 5);
      end
      check({31'h0, overflow}, 32'h0);
      check({24'h0, location_counter}, 32'h0);
      wait_busy(1'b0, 10000);
      repeat (4) @(posedge clk);
      check(32'(i_far.got.size()), 32'(2 * BLOCK_BITS));
      chk_blk(0, 32'h0000_0a5c, 12);
      chk_blk(BLOCK_BITS, 32'h0000_0003, 2);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      $display("unexpected at %0t: watchdog %h %h", $time, busy, in_use);
      conclude();
   end

   initial begin
      int n;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rreg(REG_CTRL, 32'h0000_0000);
      rreg(REG_SELECT, 32'h0000_0000);
      rreg(REG_FLAGS, 32'h0000_0000);
      bus(1'b0, REG_STATUS, 32'h0);
      check(rd & 32'h0000_0007, 32'h0);
      bus(1'b1, 5'h1c, 32'hffff_ffff);
      rreg(5'h1c, 32'h0000_0000);
      $display("test reset done");
      n = 0;
      while (oth_clk !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (oth_clk !== 1'b1 && n < 100);
      check(32'(n), 32'd16);
      $display("test idle refresh done");
      write_blk(32'h0000_0a5c, 12, 32'h0000_0002, 5'h01);
      check({27'h0, next_block}, 32'h2);
      write_blk(32'h0000_0003, 2, 32'h0000_0006, 5'h02);
      $display("test auto write done");
      read_all(32'h0000_0000, 1'b1);
      repeat (20) @(posedge clk);
      check({31'h0, busy}, 32'h0);
      rreg(REG_FLAGS, 32'h0000_0006);
      $display("test nondestructive read done");
      read_all(32'h0000_0002, 1'b0);
      rreg(REG_FLAGS, 32'h0000_0000);
      $display("test destructive read done");
      bus(1'b1, REG_CTRL, 32'h0000_0001);
      bus(1'b1, REG_SELECT, 32'h0000_0020);
      write_blk(32'h0000_0005, 3, 32'h0000_0020, 5'h05);
      check({31'h0, overflow}, 32'h1);
      i_far.send(32'h0000_0001, 4);
      repeat (20) @(posedge clk);
      check({31'h0, busy}, 32'h0);
      rreg(REG_FLAGS, 32'h0000_0020);
      bus(1'b1, REG_CMD, 32'h0000_0002);
      rreg(REG_FLAGS, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check({31'h0, overflow}, 32'h0);
      $display("test manual mode done");
      conclude();
   end
endmodule
